// ===== hdl/ats_top.sv
// Purpose: Tune supervisor of an automatic antenna coupler with an AXI4-Lite register port.
// Assumes: 10 MHz clk_sys; all pin inputs are asynchronous and are synchronised here.
// Notes:   Element search itself lives outside; search_en tells it when it may step.
//
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/100ps
`include "ats_map.svh"

// Behaviour
// - Low over flag alone means magnitude high.
// - Low under flag alone means magnitude low.
// - Both magnitude flags high means in window.
// - Tuning steps only while RF present low.
// - VSWR flag marks ratio worse than limit.
// - Tune hold asserted through whole tune cycle.
// - Tune hold drops when the cycle ends.
// - Both windows good: READY, tune hold released.
// - Persistent mismatch after good tune starts retune.
// - Untunable load lights FAULT, breaks keyline.
// - FAULT on always selects bypass.
// - New tune request clears a temporary fault.
// - Short mismatch transients are ignored.
// - FAULT lit right after power-up.
// - Power-up fault cleared only by tuning.
// - Lost memory flashes FAULT until retuned.
// - Reset brings controller to defined state.
// - Both phase flags high means in window.
// - Pad in while keyed and VSWR bad, unless FAULT is on.
// - No good tune in time: stop, FAULT.
module ats_top
	import ats_pkg::*;
#(
	parameter int unsigned TUNE_LIMIT_CYC = `ATS_TUNE_LIMIT_CYC,
	parameter int unsigned FILT_CYC       = `ATS_FILT_CYC,
	parameter int unsigned FLASH_CYC      = `ATS_FLASH_CYC
) (
	input  wire logic        clk_sys,            // System clock, 10 MHz.
	input  wire logic        sys_rst,            // Synchronous reset, active high.
	input  wire logic        tune_cmd,           // Tune pulse from transceiver, active high.
	input  wire logic        tune_button,        // Panel tune pushbutton, active high.
	input  wire logic        rf_present_n,       // Low while input RF power exists.
	input  wire logic        vswr_bad,           // High while VSWR worse than limit.
	input  wire logic        tx_keyed,           // High while transmitter is keyed.
	input  wire logic        over_magnitude_flag_n,  // Low when magnitude above window.
	input  wire logic        under_magnitude_flag_n, // Low when magnitude below window.
	input  wire logic        phase_pos_flag_n,   // Low when phase above window.
	input  wire logic        phase_neg_flag_n,   // Low when phase below window.
	input  wire logic        memory_lost,        // High when stored tunes are lost.
	output logic             tune_hold,          // Holds tune relay energised.
	output logic             ready_lamp,         // Green READY lamp.
	output logic             fault_lamp,         // Red FAULT lamp, steady or flashing.
	output logic             keyline_break,      // Interrupts transceiver keyline.
	output logic             bypass,             // Straight input-to-antenna path.
	output logic             pad_in,             // Protective attenuator switched in.
	output logic             search_en,          // Element search may step.
	output logic             retune,             // Cycle is a retune; skip stored tunes.
	input  wire logic [7:0]  s_axi_awaddr,       // Write address.
	input  wire logic        s_axi_awvalid,      // Write address valid.
	output logic             s_axi_awready,      // Write address ready.
	input  wire logic [31:0] s_axi_wdata,        // Write data.
	input  wire logic [3:0]  s_axi_wstrb,        // Write byte strobes.
	input  wire logic        s_axi_wvalid,       // Write data valid.
	output logic             s_axi_wready,       // Write data ready.
	output logic [1:0]       s_axi_bresp,        // Write response.
	output logic             s_axi_bvalid,       // Write response valid.
	input  wire logic        s_axi_bready,       // Write response ready.
	input  wire logic [7:0]  s_axi_araddr,       // Read address.
	input  wire logic        s_axi_arvalid,      // Read address valid.
	output logic             s_axi_arready,      // Read address ready.
	output logic [31:0]      s_axi_rdata,        // Read data.
	output logic [1:0]       s_axi_rresp,        // Read response.
	output logic             s_axi_rvalid,       // Read data valid.
	input  wire logic        s_axi_rready        // Read data ready.
);
	localparam int TW = $clog2(TUNE_LIMIT_CYC + 1);
	localparam int DW = $clog2(FLASH_CYC + 1);
	localparam int NP = `ATS_NUM_PINS;

	if (TUNE_LIMIT_CYC < 2 || FLASH_CYC < 2) begin : g_bad_par
		$error("ats_top: TUNE_LIMIT_CYC and FLASH_CYC must be at least 2");
	end

	typedef struct packed {
		logic [NP-1:0] s1;
		logic [NP-1:0] s2;
		logic          prev_tune;
		logic          prev_btn;
		logic [1:0]    init_cnt;
		ats_mode_t     st;
		logic [TW-1:0] timer;
		logic          flash;
		logic [DW-1:0] div;
		logic          blink;
		logic          tune_hold;
		logic          ready;
		logic          fault_lamp;
		logic          fault;
		logic          pad;
		logic          search;
		logic          retune;
		logic          ctrl_req;
		logic          aw_got;
		logic          w_got;
		logic [7:0]    waddr;
		logic [31:0]   wdata;
		logic [3:0]    wstrb;
		logic          awready;
		logic          wready;
		logic          bvalid;
		logic [1:0]    bresp;
		logic          arready;
		logic          rvalid;
		logic [31:0]   rdata;
		logic [1:0]    rresp;
	} ats_top_t;

	ats_top_t r;
	ats_top_t next_r;

	ats_filt_if vswr_f ();

	ats_persist #(
		.CYC (FILT_CYC)
	) u_vswr_persist (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.fio     (vswr_f)
	);

	// A pair of active-low flags is in window only while both stand high.
	function automatic logic in_window(input logic hi_n, input logic lo_n);
		return hi_n & lo_n;
	endfunction

	function automatic logic reg_mapped(input logic [7:0] addr);
		return addr == `ATS_OFS_CTRL || addr == `ATS_OFS_STATUS || addr == `ATS_OFS_PINS;
	endfunction

	logic [NP-1:0] pins;
	logic          tune_rise;
	logic          btn_rise;
	logic          tune_req;
	logic          rf_on;
	logic          mag_ok;
	logic          phase_ok;
	logic          accept;
	logic          init_done;

	assign pins = {memory_lost, phase_neg_flag_n, phase_pos_flag_n, under_magnitude_flag_n,
	               over_magnitude_flag_n, tx_keyed, vswr_bad, rf_present_n, tune_button, tune_cmd};

	assign tune_rise = r.s2[`ATS_PIN_TUNE] & ~r.prev_tune;
	assign btn_rise  = r.s2[`ATS_PIN_BUTTON] & ~r.prev_btn;
	assign init_done = r.init_cnt == 2'h3;
	assign tune_req  = init_done & (tune_rise | btn_rise | r.ctrl_req);
	assign rf_on     = ~r.s2[`ATS_PIN_RF_N];
	// The illegal both-low code counts as out of window, so it can never pass as a good tune.
	assign mag_ok    = in_window(r.s2[`ATS_PIN_MAG_OVER_N], r.s2[`ATS_PIN_MAG_UNDER_N]);
	assign phase_ok  = in_window(r.s2[`ATS_PIN_PH_POS_N], r.s2[`ATS_PIN_PH_NEG_N]);
	assign accept    = mag_ok & phase_ok & rf_on;

	// Only mismatch after a good tune is watched; the filter swallows whip transients.
	assign vswr_f.raw = (r.st == ATS_READY) & r.s2[`ATS_PIN_VSWR];

	always_comb begin
		next_r = r;
		next_r.s1 = pins;
		next_r.s2 = r.s1;
		next_r.prev_tune = r.s2[`ATS_PIN_TUNE];
		next_r.prev_btn = r.s2[`ATS_PIN_BUTTON];
		next_r.ctrl_req = 1'b0;
		if (!init_done) begin
			next_r.init_cnt = r.init_cnt + 2'h1;
		end
		// The memory-lost strap is caught once its synchroniser has filled.
		if (r.init_cnt == 2'h2) begin
			next_r.flash = r.s2[`ATS_PIN_MEM_LOST];
		end

		unique case (r.st)
			ATS_FAULT: begin
				if (tune_req) begin
					next_r.st = ATS_TUNE;
					next_r.timer = '0;
					next_r.retune = 1'b0;
				end
			end
			ATS_TUNE: begin
				if (tune_req) begin
					next_r.timer = '0;
				end else if (accept) begin
					next_r.st = ATS_READY;
					next_r.flash = 1'b0;
				end else if (r.timer == TW'(TUNE_LIMIT_CYC - 1)) begin
					next_r.st = ATS_FAULT;
				end else begin
					next_r.timer = r.timer + TW'(1);
				end
			end
			ATS_READY: begin
				if (vswr_f.hit) begin
					next_r.st = ATS_TUNE;
					next_r.timer = '0;
					next_r.retune = 1'b1;
				end else if (tune_req) begin
					next_r.st = ATS_TUNE;
					next_r.timer = '0;
					next_r.retune = 1'b0;
				end
			end
			default: begin
				next_r.st = ATS_FAULT;
			end
		endcase

		// The flash divider is a slow enable; the lamp toggles once per interval.
		if (r.div == DW'(FLASH_CYC - 1)) begin
			next_r.div = '0;
			next_r.blink = ~r.blink;
		end else begin
			next_r.div = r.div + DW'(1);
		end

		next_r.tune_hold = next_r.st == ATS_TUNE;
		next_r.ready = next_r.st == ATS_READY;
		next_r.fault = next_r.st == ATS_FAULT;
		next_r.fault_lamp = next_r.fault & (~next_r.flash | next_r.blink);
		next_r.search = (next_r.st == ATS_TUNE) & ~r.s2[`ATS_PIN_RF_N] & ~accept;
		next_r.pad = r.s2[`ATS_PIN_KEYED] & r.s2[`ATS_PIN_VSWR] & ~next_r.fault;

		// Write channel: address and data are taken in either order, answered once both are in.
		if (r.awready && s_axi_awvalid) begin
			next_r.aw_got = 1'b1;
			next_r.waddr = s_axi_awaddr;
		end
		if (r.wready && s_axi_wvalid) begin
			next_r.w_got = 1'b1;
			next_r.wdata = s_axi_wdata;
			next_r.wstrb = s_axi_wstrb;
		end
		if (r.bvalid && s_axi_bready) begin
			next_r.bvalid = 1'b0;
		end
		if (r.aw_got && r.w_got && !r.bvalid) begin
			next_r.aw_got = 1'b0;
			next_r.w_got = 1'b0;
			next_r.bvalid = 1'b1;
			next_r.bresp = reg_mapped(r.waddr) ? `ATS_RESP_OKAY : `ATS_RESP_SLVERR;
			if (r.waddr == `ATS_OFS_CTRL && r.wstrb[0]) begin
				next_r.ctrl_req = r.wdata[`ATS_CTRL_TUNE];
			end
		end
		next_r.awready = ~next_r.aw_got & ~next_r.bvalid;
		next_r.wready = ~next_r.w_got & ~next_r.bvalid;

		if (r.rvalid && s_axi_rready) begin
			next_r.rvalid = 1'b0;
		end
		if (r.arready && s_axi_arvalid) begin
			next_r.rvalid = 1'b1;
			next_r.rresp = reg_mapped(s_axi_araddr) ? `ATS_RESP_OKAY : `ATS_RESP_SLVERR;
			next_r.rdata = '0;
			if (s_axi_araddr == `ATS_OFS_STATUS) begin
				next_r.rdata[`ATS_ST_STATE_LO +: 2] = r.st;
				next_r.rdata[`ATS_ST_TUNE_HOLD] = r.tune_hold;
				next_r.rdata[`ATS_ST_READY] = r.ready;
				next_r.rdata[`ATS_ST_FAULT] = r.fault;
				next_r.rdata[`ATS_ST_FLASH] = r.flash;
				next_r.rdata[`ATS_ST_RETUNE] = r.retune;
				next_r.rdata[`ATS_ST_PAD] = r.pad;
				next_r.rdata[`ATS_ST_SEARCH] = r.search;
				next_r.rdata[`ATS_ST_MAG_OK] = mag_ok;
				next_r.rdata[`ATS_ST_PHASE_OK] = phase_ok;
				next_r.rdata[`ATS_ST_VSWR_QUAL] = vswr_f.hit;
			end else if (s_axi_araddr == `ATS_OFS_PINS) begin
				next_r.rdata[NP-1:0] = r.s2;
			end
		end
		next_r.arready = ~next_r.rvalid;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			r <= '0;
			r.st <= ATS_FAULT;
			r.fault <= 1'b1;
			r.fault_lamp <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign tune_hold     = r.tune_hold;
	assign ready_lamp    = r.ready;
	assign fault_lamp    = r.fault_lamp;
	assign keyline_break = r.fault;
	assign bypass        = r.fault;
	assign pad_in        = r.pad;
	assign search_en     = r.search;
	assign retune        = r.retune;
	assign s_axi_awready = r.awready;
	assign s_axi_wready  = r.wready;
	assign s_axi_bvalid  = r.bvalid;
	assign s_axi_bresp   = r.bresp;
	assign s_axi_arready = r.arready;
	assign s_axi_rvalid  = r.rvalid;
	assign s_axi_rdata   = r.rdata;
	assign s_axi_rresp   = r.rresp;

	property p_hold_start;
		@(posedge clk_sys) disable iff (sys_rst) tune_req && r.st == ATS_FAULT |=> tune_hold && !bypass;
	endproperty
	a_hold_start: assert property (p_hold_start) else $error("tune request did not latch the relay");

	property p_hold_end;
		@(posedge clk_sys) disable iff (sys_rst) $fell(tune_hold) |-> ready_lamp ^ keyline_break;
	endproperty
	a_hold_end: assert property (p_hold_end) else $error("tune hold dropped without an outcome");

	property p_ready_cause;
		@(posedge clk_sys) disable iff (sys_rst) $rose(ready_lamp) |-> $past(mag_ok) && $past(phase_ok) && !pad_in;
	endproperty
	a_ready_cause: assert property (p_ready_cause) else $error("READY lit without both windows");

	property p_fault_bypass;
		@(posedge clk_sys) disable iff (sys_rst) keyline_break |-> bypass && !ready_lamp && !tune_hold;
	endproperty
	a_fault_bypass: assert property (p_fault_bypass) else $error("fault without bypass");

	property p_power_fault;
		@(posedge clk_sys) $fell(sys_rst) |-> keyline_break && fault_lamp && !tune_hold;
	endproperty
	a_power_fault: assert property (p_power_fault) else $error("fault not shown after reset");

	property p_fault_clear;
		@(posedge clk_sys) disable iff (sys_rst) $fell(keyline_break) |-> tune_hold && $past(tune_req);
	endproperty
	a_fault_clear: assert property (p_fault_clear) else $error("fault cleared without a tune");

	property p_rf_gate;
		@(posedge clk_sys) disable iff (sys_rst) r.s2[`ATS_PIN_RF_N] |=> !search_en;
	endproperty
	a_rf_gate: assert property (p_rf_gate) else $error("search stepped without RF");

	property p_pad;
		@(posedge clk_sys) disable iff (sys_rst)
			r.s2[`ATS_PIN_KEYED] && r.s2[`ATS_PIN_VSWR] && !next_r.fault |=> pad_in;
	endproperty
	a_pad: assert property (p_pad) else $error("pad not switched in");

	property p_timeout;
		@(posedge clk_sys) disable iff (sys_rst)
			r.st == ATS_TUNE && r.timer == TW'(TUNE_LIMIT_CYC - 1) && !tune_req && !accept |=> keyline_break;
	endproperty
	a_timeout: assert property (p_timeout) else $error("tune limit passed without fault");

	property p_retune;
		@(posedge clk_sys) disable iff (sys_rst) ready_lamp && vswr_f.hit |=> tune_hold && retune;
	endproperty
	a_retune: assert property (p_retune) else $error("mismatch after good tune not retuned");

	property p_one_pulse;
		@(posedge clk_sys) disable iff (sys_rst) tune_rise |=> !tune_rise;
	endproperty
	a_one_pulse: assert property (p_one_pulse) else $error("one tune pulse gave two starts");
endmodule

// ===== inc/ats_map.svh
// Purpose: Offsets, field positions and timing counts of the antenna tune supervisor.
// Assumes: 10 MHz system clock; 32-bit AXI4-Lite register words.
// Notes:   Times are kept in milliseconds; cycle counts are derived from them.
`ifndef ATS_MAP_SVH
`define ATS_MAP_SVH

`define ATS_CLK_KHZ         10000
`define ATS_TUNE_LIMIT_MS   10000
`define ATS_FILT_TIME_MS    50
`define ATS_FLASH_TIME_MS   250
`define ATS_TUNE_LIMIT_CYC  (`ATS_TUNE_LIMIT_MS * `ATS_CLK_KHZ)
`define ATS_FILT_CYC        (`ATS_FILT_TIME_MS * `ATS_CLK_KHZ)
`define ATS_FLASH_CYC       (`ATS_FLASH_TIME_MS * `ATS_CLK_KHZ)

`define ATS_OFS_CTRL        8'h00
`define ATS_OFS_STATUS      8'h04
`define ATS_OFS_PINS        8'h08

`define ATS_CTRL_TUNE       0
`define ATS_ST_STATE_LO     0
`define ATS_ST_TUNE_HOLD    4
`define ATS_ST_READY        5
`define ATS_ST_FAULT        6
`define ATS_ST_FLASH        7
`define ATS_ST_RETUNE       8
`define ATS_ST_PAD          9
`define ATS_ST_SEARCH       10
`define ATS_ST_MAG_OK       11
`define ATS_ST_PHASE_OK     12
`define ATS_ST_VSWR_QUAL    13

`define ATS_PIN_TUNE        0
`define ATS_PIN_BUTTON      1
`define ATS_PIN_RF_N        2
`define ATS_PIN_VSWR        3
`define ATS_PIN_KEYED       4
`define ATS_PIN_MAG_OVER_N  5
`define ATS_PIN_MAG_UNDER_N 6
`define ATS_PIN_PH_POS_N    7
`define ATS_PIN_PH_NEG_N    8
`define ATS_PIN_MEM_LOST    9
`define ATS_NUM_PINS        10

`define ATS_RESP_OKAY       2'h0
`define ATS_RESP_SLVERR     2'h2

`endif

// ===== inc/ats_pkg.sv
// Purpose: Types shared by the antenna tune supervisor modules.
// Assumes: Nothing beyond the map header.
// Notes:   States carry no explicit codes; they take 0, 1 and 2 in the order listed.
package ats_pkg;
	typedef enum logic [1:0] {
		ATS_FAULT,
		ATS_TUNE,
		ATS_READY
	} ats_mode_t;
endpackage

// ===== inc/ats_filt_if.sv
// Purpose: Carries a raw mismatch level to the persistence filter and its verdict back.
// Assumes: Both ends run on the system clock.
// Notes:   The raw level is already synchronised before it enters here.
`timescale 1ns/100ps
interface ats_filt_if;
	logic raw;
	logic hit;
	modport user (output raw, input hit);
	modport filt (input raw, output hit);
endinterface

// ===== hdl/ats_persist.sv
// Purpose: Passes a level only after it has stood for a full interval of clock cycles.
// Assumes: Input is synchronous to clk_sys.
// Notes:   Any drop of the input restarts the interval.
`timescale 1ns/100ps
module ats_persist
	import ats_pkg::*;
#(
	parameter int unsigned CYC = 500000
) (
	input  wire logic  clk_sys, // System clock.
	input  wire logic  sys_rst, // Synchronous reset, active high.
	ats_filt_if.filt   fio      // Raw level in, qualified level out.
);
	localparam int CW = $clog2(CYC + 1);

	if (CYC < 2) begin : g_bad_cyc
		$error("ats_persist: CYC must be at least 2");
	end

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          hit;
	} ats_persist_t;

	ats_persist_t r;
	ats_persist_t next_r;

	always_comb begin
		next_r = r;
		if (!fio.raw) begin
			next_r.cnt = '0;
			next_r.hit = 1'b0;
		end else if (r.cnt == CW'(CYC - 1)) begin
			next_r.hit = 1'b1;
		end else begin
			next_r.cnt = r.cnt + CW'(1);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign fio.hit = r.hit;

	property p_persist_drop;
		@(posedge clk_sys) disable iff (sys_rst) !fio.raw |=> !fio.hit;
	endproperty
	a_persist_drop: assert property (p_persist_drop) else $error("qualified level outlived its input");

	property p_persist_rise;
		@(posedge clk_sys) disable iff (sys_rst) $rose(fio.hit) |-> $past(fio.raw) && r.cnt == CW'(CYC - 1);
	endproperty
	a_persist_rise: assert property (p_persist_rise) else $error("level qualified before full interval");
endmodule

// ===== verif/ats_xcvr_model.sv
// Purpose: Transceiver model that keys, supplies tune carrier and sends tune pulses.
// Assumes: Carrier reaches the coupler only while keyed and enabled by the bench.
// Notes:   In automatic mode a fresh FAULT makes it send a retune pulse by itself.
`timescale 1ns/100ps
module ats_xcvr_model (
	input  wire logic clk_sys,      // System clock.
	input  wire logic tune_hold,    // Tune relay held by the coupler.
	input  wire logic fault_lamp,   // Coupler FAULT lamp.
	input  wire logic carrier_en,   // Carrier may be supplied.
	input  wire logic key_req,      // Operator keys the transmitter.
	input  wire logic auto_mode,    // Retune after a fault without the operator.
	output logic      tune_cmd,     // Tune pulse, active high.
	output logic      rf_present_n, // Low while carrier reaches the coupler.
	output logic      tx_keyed      // Transmitter keyed.
);
	logic       man_pulse = 1'b0;
	logic       fault_q   = 1'b1;
	logic [1:0] auto_cnt  = 2'h0;

	// The held relay keys the set, which then supplies carrier for tuning.
	assign tx_keyed     = tune_hold | key_req;
	assign rf_present_n = ~(tx_keyed & carrier_en);
	assign tune_cmd     = man_pulse | (auto_cnt != 2'h0);

	// Three-cycle pulse keeps the coupler's two-cycle minimum width.
	always @(posedge clk_sys) begin
		fault_q <= fault_lamp;
		if (auto_mode && fault_lamp && !fault_q) begin
			auto_cnt <= 2'h3;
		end else if (auto_cnt != 2'h0) begin
			auto_cnt <= auto_cnt - 2'h1;
		end
	end

	task automatic pulse(input int len);
		man_pulse <= 1'b1;
		repeat (len) @(posedge clk_sys);
		man_pulse <= 1'b0;
	endtask
endmodule

// ===== verif/testbench.sv
// Purpose: Self-checking bench of the antenna tune supervisor.
// Assumes: Short counts: limit 200, filter 8, flash 4 cycles.
// Notes:   Outputs are polled at the falling edge and checked at the rising edge, before they change.
`timescale 1ns/100ps
module testbench;
	localparam int LIM = 200;
	localparam int FILT = 8;
	localparam int HOLD = 0, RDY = 1, FLT = 2, BYP = 4, PAD = 5;
	logic        clk_sys = 1'b0, sys_rst = 1'b1, tune_button = 1'b0, vswr_bad = 1'b0;
	logic        memory_lost = 1'b0, carrier_en = 1'b1, key_req = 1'b0, auto_mode = 1'b0;
	logic [3:0]  win_n = 4'hF;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, hold_q;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic        tune_hold, ready_lamp, fault_lamp, keyline_break, bypass, pad_in, search_en, retune;
	logic        tune_cmd, rf_present_n, tx_keyed;
	logic [7:0]  obs;
	int          err_count = 0, num_checks = 0, hold_rises = 0;

	assign obs = {retune, search_en, pad_in, bypass, keyline_break, fault_lamp, ready_lamp, tune_hold};

	ats_top #(.TUNE_LIMIT_CYC(LIM), .FILT_CYC(FILT), .FLASH_CYC(4)) DUT (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .tune_cmd(tune_cmd), .tune_button(tune_button),
		.rf_present_n(rf_present_n), .vswr_bad(vswr_bad), .tx_keyed(tx_keyed),
		.over_magnitude_flag_n(win_n[3]), .under_magnitude_flag_n(win_n[2]),
		.phase_pos_flag_n(win_n[1]), .phase_neg_flag_n(win_n[0]), .memory_lost(memory_lost),
		.tune_hold(tune_hold), .ready_lamp(ready_lamp), .fault_lamp(fault_lamp),
		.keyline_break(keyline_break), .bypass(bypass), .pad_in(pad_in), .search_en(search_en),
		.retune(retune), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));

	ats_xcvr_model xcvr (
		.clk_sys(clk_sys), .tune_hold(tune_hold), .fault_lamp(fault_lamp), .carrier_en(carrier_en),
		.key_req(key_req), .auto_mode(auto_mode), .tune_cmd(tune_cmd), .rf_present_n(rf_present_n),
		.tx_keyed(tx_keyed));

	initial begin
		forever #50 clk_sys = ~clk_sys;
	end

	always @(negedge clk_sys) begin
		if (tune_hold === 1'b1 && hold_q !== 1'b1)
			hold_rises = hold_rises + 1;
		hold_q = tune_hold;
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_up(input string what);
		err_count++;
		$display("CHECK FAILED %s expected answer seen timeout", what);
		wrap_up();
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic wait_bit(input int idx, input logic val, input int bound, output int n);
		for (n = 0; n < bound; n++) begin
			@(negedge clk_sys);
			if (obs[idx] === val)
				break;
		end
		@(posedge clk_sys);
		if (n == bound)
			give_up("output wait");
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		int n;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_sys);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid && bready) begin
				resp = bresp;
				bready <= 1'b0;
				break;
			end
		end
		if (n == 50)
			give_up("write response");
		// One idle edge keeps a following call from driving bready twice in one step.
		@(posedge clk_sys);
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_sys);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid && rready) begin
				d = rdata;
				resp = rresp;
				rready <= 1'b0;
				break;
			end
		end
		if (n == 50)
			give_up("read data");
		@(posedge clk_sys);
	endtask

	task automatic press_button();
		tune_button <= 1'b1;
		cyc(3);
		tune_button <= 1'b0;
	endtask

	task automatic t_power();
		logic [31:0] d;
		logic [1:0]  r;
		cyc(30);
		check("outputs after power up", obs, 8'h1C);
		axi_rd(8'h04, d, r);
		check("status after power up", {r, d}, {2'h0, 32'h1840});
		axi_rd(8'h08, d, r);
		check("pins after power up", {r, d}, {2'h0, 32'h1E4});
		axi_rd(8'h0C, d, r);
		check("unmapped read", {r, d}, {2'h2, 32'h0});
		axi_wr(8'h0C, 32'h1, r);
		check("unmapped write", r, 2'h2);
		cyc(10);
		check("fault kept without tune", obs, 8'h1C);
		$display("test power done");
	endtask

	task automatic t_window();
		int n;
		win_n <= 4'h7;
		press_button();
		wait_bit(HOLD, 1'b1, 10, n);
		check("fault cleared by button", {fault_lamp, bypass}, 2'b00);
		// Each pattern pulls exactly one flag low; none may be taken as a match.
		for (int i = 0; i < 4; i++) begin
			win_n <= ~(4'h8 >> i);
			cyc(12);
			check("held while out of window", {ready_lamp, tune_hold, search_en}, 3'b011);
		end
		win_n <= 4'hF;
		wait_bit(RDY, 1'b1, 10, n);
		check("accepted tune", obs, 8'h02);
		$display("test window done");
	endtask

	task automatic t_vswr();
		int n;
		key_req <= 1'b1;
		vswr_bad <= 1'b1;
		cyc(4);
		vswr_bad <= 1'b0;
		wait_bit(PAD, 1'b1, 8, n);
		cyc(20);
		check("short mismatch ignored", obs, 8'h02);
		// A real mismatch leaves the load out of window, else the retune would end at once.
		win_n <= 4'h7;
		vswr_bad <= 1'b1;
		wait_bit(HOLD, 1'b1, 30, n);
		check("filter interval", n >= FILT, 1'b1);
		cyc(2);
		check("retune with pad", {retune, pad_in, ready_lamp}, 3'b110);
		key_req <= 1'b0;
		win_n <= 4'h7;
		cyc(6);
		check("search with carrier", search_en, 1'b1);
		carrier_en <= 1'b0;
		auto_mode <= 1'b1;
		cyc(6);
		check("search stops without carrier", search_en, 1'b0);
		wait_bit(FLT, 1'b1, 260, n);
		check("tune limit", (n + 15 > LIM - 5) && (n + 15 < LIM + 5), 1'b1);
		check("fault outputs", obs[4:0], 5'h1C);
		vswr_bad <= 1'b0;
		win_n <= 4'hF;
		carrier_en <= 1'b1;
		wait_bit(HOLD, 1'b1, 15, n);
		wait_bit(RDY, 1'b1, 15, n);
		check("automatic retune", {retune, fault_lamp}, 2'b00);
		auto_mode <= 1'b0;
		$display("test vswr done");
	endtask

	task automatic t_cmd();
		int          h0;
		int          n;
		logic [31:0] d;
		logic [1:0]  r;
		h0 = hold_rises;
		xcvr.pulse(20);
		cyc(10);
		check("one cycle per pulse", hold_rises - h0, 1);
		check("ready after pulse", obs, 8'h02);
		axi_wr(8'h00, 32'h1, r);
		check("control write", r, 2'h0);
		wait_bit(HOLD, 1'b1, 10, n);
		wait_bit(RDY, 1'b1, 10, n);
		axi_rd(8'h04, d, r);
		check("status when ready", {r, d}, {2'h0, 32'h1822});
		$display("test command done");
	endtask

	task automatic t_flash();
		int          toggles;
		int          n;
		logic        last;
		logic [31:0] d;
		logic [1:0]  r;
		memory_lost <= 1'b1;
		sys_rst <= 1'b1;
		cyc(6);
		sys_rst <= 1'b0;
		cyc(4);
		last = fault_lamp;
		toggles = 0;
		for (int i = 0; i < 40; i++) begin
			@(negedge clk_sys);
			if (fault_lamp !== last)
				toggles++;
			last = fault_lamp;
		end
		check("lamp flashes", toggles >= 5, 1'b1);
		check("bypass while flashing", {keyline_break, bypass}, 2'b11);
		@(posedge clk_sys);
		press_button();
		wait_bit(RDY, 1'b1, 15, n);
		axi_rd(8'h04, d, r);
		check("flash cleared", d[7:6], 2'b00);
		$display("test flash done");
	endtask

	initial begin
		cyc(6);
		sys_rst <= 1'b0;
		t_power();
		t_window();
		t_vswr();
		t_cmd();
		t_flash();
		wrap_up();
	end
endmodule
